/* File: core/atl_throttle.sv */
`timescale 1ns/1ps

// How it works
// RULE1: status shows 8-bit level, step four activations
// RULE2: only hardware updates level within limits
// RULE3: decisions use unlatched global throttle signal
// RULE4: debug mode ends global throttle after 2 windows
// RULE5: cool, hunting, no global: apply low limit
// RULE6: hunting off, no global: apply low limit
// RULE7: software keeps low limit at most 168
// RULE8: low limit writes above 168 clamp to 168
// RULE9: low limit code counts four activations, 0 unlimited
// RULE10: global status set when window count exceeds limit
// RULE11: middle temperature or global throttle: mid limit
// RULE12: hot: high limit, slammed or staircase by mode
// RULE13: hunting off: temperature has no effect
// RULE14: reset leaves level and low limit zero
module atl_throttle (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [atl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [atl_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [atl_pkg::DATA_W-1:0] regRdData,
    input wire logic tempAboveLow,
    input wire logic tempAboveMid,
    input wire logic windowEnd,
    input wire logic windowOverLimit,
    output logic [7:0] currentThrottleLevel,
    output logic globalThrottleStatus
);

    // caps a code to the largest legal limit
    // one helper for all three limit fields, so they clamp alike
    function automatic logic [7:0] clampCode(input logic [7:0] code);
        clampCode = (code > atl_pkg::LEVEL_MAX) ? atl_pkg::LEVEL_MAX : code;
    endfunction

    // reset release through two flops
    // both flops clear at once; the release needs two edges,
    // so no flop of the block ever sees a runt release
    // the first flop feeds only the second, never the logic
    logic rstSync1_reg;
    logic rstSync2_reg;
    logic rstN;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end

    // every other process resets on this released copy
    assign rstN = rstSync2_reg;

    // software programmed limits and control bits
    logic [7:0] lowLimit_reg;
    logic [7:0] midLimit_reg;
    logic [7:0] highLimit_reg;
    logic huntingEnable_reg;
    logic highLevelMode_reg;
    logic debugMode_reg;

    // applied level, the value the status field shows
    logic [7:0] level_reg;
    logic [7:0] level_next;

    // global throttle flag and its run of quiet windows
    logic global_reg;
    logic [4:0] quiet_reg;
    logic [4:0] quiet_next;

    // staircase step divider
    logic [7:0] stepCnt_reg;

    // read path, one word held for one cycle
    logic [atl_pkg::DATA_W-1:0] rdData_reg;
    logic [atl_pkg::DATA_W-1:0] rdData_next;

    // which limit drives the level; kept to spot staircase entry
    atl_pkg::atl_sel_t sel_reg;
    atl_pkg::atl_sel_t sel_next;

    // address decode
    // exact compare on the byte offset, so no alias takes a stray write
    wire hitLow = (regAddr == atl_pkg::REG_LOW_LIMIT);
    wire hitStatus = (regAddr == atl_pkg::REG_STATUS);
    wire hitConfig = (regAddr == atl_pkg::REG_CONFIG);
    // write strobes qualified by the decoded offset; the status has none
    wire wrLow = regWrEn && hitLow;
    wire wrConfig = regWrEn && hitConfig;

    // low limit field, clamped on the way in
    // the clamp sits on the write path, so a read never shows an illegal code
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            lowLimit_reg <= atl_pkg::LOW_LIMIT_RST; // [RULE14]
        end else if (wrLow) begin
            lowLimit_reg <= clampCode(regWrData[7:0]); // [RULE8] [RULE9]
        end
    end

    // mid and high limits plus mode bits share one word
    // mid and high clamp like the low limit; bits outside the layout drop
    // a write here reaches the level in the very next cycle
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            // hunting, mode and debug all start off
            midLimit_reg <= atl_pkg::MID_RST;
            highLimit_reg <= atl_pkg::HIGH_RST;
            huntingEnable_reg <= 1'b0;
            highLevelMode_reg <= 1'b0;
            debugMode_reg <= 1'b0;
        end else if (wrConfig) begin
            // all fields of the word land together
            midLimit_reg <= clampCode(regWrData[atl_pkg::CFG_MID_LSB +: 8]);
            highLimit_reg <= clampCode(regWrData[atl_pkg::CFG_HIGH_LSB +: 8]);
            huntingEnable_reg <= regWrData[atl_pkg::CFG_HUNT_BIT];
            highLevelMode_reg <= regWrData[atl_pkg::CFG_MODE_BIT];
            debugMode_reg <= regWrData[atl_pkg::CFG_DEBUG_BIT];
        end
    end

    // global throttle: a window over the limit starts it
    // the over-limit flag only counts while the window end pulse is high
    wire windowHot = windowEnd && windowOverLimit; // [RULE10]
    // a window that ended within the limit counts as quiet
    wire windowQuiet = windowEnd && !windowOverLimit;
    // debug mode needs only two quiet windows in a row
    // the normal run is sixteen windows
    wire [4:0] quietNeed = debugMode_reg ? atl_pkg::QUIET_WIN_DEBUG
                                         : atl_pkg::QUIET_WIN_NORMAL; // [RULE4]
    // the window now ending is counted before the compare,
    // so the flag drops at the edge of the last quiet window;
    // at least, not equal, so a switch to debug mid run still ends it
    wire quietDone = global_reg
                     && windowQuiet
                     && (quiet_reg + 5'h01 >= quietNeed);

    // unlatched copy sees this cycle's window, so no stale decision
    // a hot window and the last quiet window never meet in one pulse,
    // so there is no set and clear clash to settle here
    wire globalUnlatched = windowHot || (global_reg && !quietDone); // [RULE3]

    // quiet window counter restarts on any hot window
    // the count only runs while global throttling is on
    always_comb begin
        // hold the count between window pulses
        quiet_next = quiet_reg;
        if (windowHot || !global_reg) begin
            // fresh start for the next throttling episode
            quiet_next = 5'h00;
        end else if (windowQuiet) begin
            // one more quiet window, or done
            quiet_next = quietDone ? 5'h00 : quiet_reg + 5'h01;
        end
    end

    // registered global status; the selection never waits for it
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            global_reg <= 1'b0;
            quiet_reg <= 5'h00;
        end else begin
            global_reg <= globalUnlatched; // [RULE10]
            quiet_reg <= quiet_next;
        end
    end

    // staircase step enable from a divider
    // free running: the first step after entry may come early by up to
    // one step period, which is the price of a shared divider
    wire stepTick = (stepCnt_reg == atl_pkg::STEP_LAST);

    // divider count wraps after one step period
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            stepCnt_reg <= 8'h00;
        end else begin
            stepCnt_reg <= stepTick ? 8'h00 : stepCnt_reg + 8'h01;
        end
    end

    // temperature only counts with hunting on
    // with hunting off both flags drop, leaving the global throttle alone
    wire hot = huntingEnable_reg && tempAboveMid; // [RULE13]
    wire warm = huntingEnable_reg && tempAboveLow; // [RULE13]

    // limit selection: hot beats global, global beats cool
    // the unlatched global signal is used, so a hot window throttles
    // in the same edge that sets the status bit
    always_comb begin
        sel_next = atl_pkg::SEL_LOW;
        if (hot) begin
            // hot has priority over the global throttle
            sel_next = highLevelMode_reg ? atl_pkg::SEL_HIGH
                                         : atl_pkg::SEL_STAIR; // [RULE12]
        end else if (warm || globalUnlatched) begin
            // middle range, or global throttling on
            sel_next = atl_pkg::SEL_MID; // [RULE11]
        end else begin
            // cool, or hunting off with global throttling quiet
            sel_next = atl_pkg::SEL_LOW; // [RULE5] [RULE6]
        end
    end

    // staircase range lies between mid and high limits
    // lower codes mean fewer activations, so the steps count down to high
    // a level outside the range, e.g. after a limit write, restarts at mid
    wire stairOut = (level_reg > midLimit_reg) || (level_reg < highLimit_reg);
    // entry: a fresh staircase choice, or a level pushed outside
    wire stairEntry = (sel_reg != atl_pkg::SEL_STAIR) || stairOut;

    // level follows the selected limit
    // chosen afresh each cycle from the live limits and inputs
    always_comb begin
        level_next = level_reg;
        case (sel_next)
            // base limit
            atl_pkg::SEL_LOW: begin
                level_next = lowLimit_reg; // [RULE5] [RULE6]
            end
            // middle limit
            atl_pkg::SEL_MID: begin
                level_next = midLimit_reg; // [RULE11]
            end
            // slammed to the high limit
            atl_pkg::SEL_HIGH: begin
                level_next = highLimit_reg; // [RULE12]
            end
            atl_pkg::SEL_STAIR: begin
                // entry lands at mid, then one step per tick toward high
                if (stairEntry) begin
                    level_next = midLimit_reg; // [RULE12]
                end else if (stepTick && (level_reg > highLimit_reg)) begin
                    level_next = level_reg - 8'h01; // [RULE12]
                end
            end
            default: begin
                // unreachable with one-hot codes; falls back to the base limit
                level_next = lowLimit_reg;
            end
        endcase
    end

    // only this process writes the level; the status is read only
    // sel_reg remembers the last choice so staircase entry can be seen
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            sel_reg <= atl_pkg::SEL_LOW;
            level_reg <= atl_pkg::LEVEL_RST; // [RULE14]
        end else begin
            sel_reg <= sel_next;
            level_reg <= level_next; // [RULE2]
        end
    end

    // read mux; unmapped offsets read zero
    // the word is only built under a read strobe, so the bus shows zero
    // between reads and a missed sample cannot look like fresh data
    always_comb begin
        rdData_next = '0;
        if (regRdEn) begin
            if (hitLow) begin
                // low limit, upper bits zero
                rdData_next[7:0] = lowLimit_reg;
            end else if (hitStatus) begin
                // level and the registered global flag
                rdData_next[atl_pkg::STS_LEVEL_LSB +: 8] = level_reg; // [RULE1]
                rdData_next[atl_pkg::STS_GLOBAL_BIT] = global_reg;
            end else if (hitConfig) begin
                // mid, high and the three control bits
                rdData_next[atl_pkg::CFG_MID_LSB +: 8] = midLimit_reg;
                rdData_next[atl_pkg::CFG_HIGH_LSB +: 8] = highLimit_reg;
                rdData_next[atl_pkg::CFG_HUNT_BIT] = huntingEnable_reg;
                rdData_next[atl_pkg::CFG_MODE_BIT] = highLevelMode_reg;
                rdData_next[atl_pkg::CFG_DEBUG_BIT] = debugMode_reg;
            end
        end
    end

    // read data stand one cycle, zero otherwise
    // the flop also keeps the decode out of the output's path
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdData_reg <= '0;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    // every output comes straight from a flop,
    // so the pins never glitch with the bus decode
    assign regRdData = rdData_reg;
    assign currentThrottleLevel = level_reg; // [RULE1]
    assign globalThrottleStatus = global_reg;

endmodule

/* File: core/atl_pkg.sv */
package atl_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] REG_LOW_LIMIT = 8'h64;
    localparam logic [7:0] REG_STATUS = 8'h68;
    localparam logic [7:0] REG_CONFIG = 8'h6C;
    // status field layout
    localparam int STS_LEVEL_LSB = 0;
    localparam int STS_GLOBAL_BIT = 8;
    // config field layout
    localparam int CFG_MID_LSB = 0;
    localparam int CFG_HIGH_LSB = 8;
    localparam int CFG_HUNT_BIT = 16;
    localparam int CFG_MODE_BIT = 17;
    localparam int CFG_DEBUG_BIT = 18;
    // reset values
    localparam logic [7:0] LOW_LIMIT_RST = 8'h00;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [7:0] MID_RST = 8'h00;
    localparam logic [7:0] HIGH_RST = 8'h00;
    // largest legal code: 168 means 672 activations per window
    localparam logic [7:0] LEVEL_MAX = 8'hA8;
    // quiet windows needed before global throttling ends
    localparam logic [4:0] QUIET_WIN_NORMAL = 5'h10;
    localparam logic [4:0] QUIET_WIN_DEBUG = 5'h02;
    // staircase step time and clock period
    localparam int STEP_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);
    // applied limit selection
    typedef enum logic [3:0] {
        SEL_LOW = 4'h1,
        SEL_MID = 4'h2,
        SEL_HIGH = 4'h4,
        SEL_STAIR = 4'h8
    } atl_sel_t;
endpackage

/* File: test/atl_throttle_checker.sv */
`timescale 1ns/1ps
module atl_throttle_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [atl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [atl_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [atl_pkg::DATA_W-1:0] regRdData,
    input wire logic tempAboveLow,
    input wire logic tempAboveMid,
    input wire logic windowEnd,
    input wire logic windowOverLimit,
    input wire logic [7:0] currentThrottleLevel,
    input wire logic globalThrottleStatus
);
    logic [1:0] upCnt;
    logic [7:0] lowSh;
    logic [18:0] cfgSh;
    logic [4:0] quiet;
    // decoded helpers; ready waits out the two-flop reset release
    wire ready = upCnt[1];
    wire hotWin = windowEnd && windowOverLimit;
    wire hunt = cfgSh[16];
    wire quietLast = quiet >= (cfgSh[18] ? 5'h01 : 5'h0F);
    wire calm = ready && !regWrEn;
    function automatic logic [7:0] clampLvl(input logic [7:0] v);
        return (v > atl_pkg::LEVEL_MAX) ? atl_pkg::LEVEL_MAX : v;
    endfunction
    // shadow of the writable fields, so the low, mid and slammed high levels can be predicted from the ports alone
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            upCnt <= 2'h0;
            lowSh <= 8'h00;
            cfgSh <= 19'h0;
            quiet <= 5'h00;
        end else begin
            upCnt <= ready ? upCnt : upCnt + 2'h1;
            if (regWrEn && regAddr == atl_pkg::REG_LOW_LIMIT) lowSh <= clampLvl(regWrData[7:0]);
            if (regWrEn && regAddr == atl_pkg::REG_CONFIG) cfgSh <= {regWrData[18:16],
                clampLvl(regWrData[15:8]), clampLvl(regWrData[7:0])};
            quiet <= (hotWin || !globalThrottleStatus) ? 5'h00 : quiet + {4'h0, windowEnd};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_reset_zero_out: assert property (!ready |-> currentThrottleLevel == 8'h00 && !globalThrottleStatus)
        else $error("output not zero before reset release");
    a_low_selected: assert property (calm && !globalThrottleStatus && !hotWin && !(hunt && tempAboveLow)
        |=> currentThrottleLevel == lowSh) else $error("low limit not applied");
    a_mid_selected: assert property (calm && !(hunt && tempAboveMid) && ((globalThrottleStatus && !windowEnd)
        || hotWin || (hunt && tempAboveLow)) |=> currentThrottleLevel == cfgSh[7:0]) else $error("mid limit not applied");
    a_high_slammed: assert property (calm && hunt && cfgSh[17] && tempAboveMid |=> currentThrottleLevel == cfgSh[15:8])
        else $error("high limit not applied");
    a_global_set: assert property (ready && hotWin |=> globalThrottleStatus)
        else $error("global status not set");
    a_global_hold: assert property (ready && globalThrottleStatus && !(windowEnd && !windowOverLimit && quietLast)
        |=> globalThrottleStatus) else $error("global status dropped early");
    a_global_clear: assert property (ready && globalThrottleStatus && windowEnd && !windowOverLimit && quietLast
        |=> !globalThrottleStatus) else $error("global status not cleared");
    a_status_read: assert property (ready && regRdEn && regAddr == atl_pkg::REG_STATUS
        |=> regRdData == {23'h0, $past(globalThrottleStatus), $past(currentThrottleLevel)}) else $error("bad status read");
endmodule

bind atl_throttle atl_throttle_checker u_chk (.clk_sys, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .tempAboveLow, .tempAboveMid, .windowEnd, .windowOverLimit, .currentThrottleLevel, .globalThrottleStatus);

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic tempAboveLow = 1'b0, tempAboveMid = 1'b0, windowEnd = 1'b0, windowOverLimit = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData;
    logic [7:0] currentThrottleLevel;
    logic globalThrottleStatus;
    int errors = 0;
    int checked = 0;
    atl_throttle uut (.clk_sys, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .tempAboveLow,
        .tempAboveMid, .windowEnd, .windowOverLimit, .currentThrottleLevel, .globalThrottleStatus);
    // 20 MHz clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic stop_test;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // each access leaves one idle cycle, so no strobe is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1 chk("read data", e, regRdData);
    endtask
    // upper bits are junk on purpose: only the low byte is the limit
    task automatic lowChk(input logic [7:0] w, input logic [7:0] e);
        wr(atl_pkg::REG_LOW_LIMIT, {24'hFFFFFF, w});
        rd(atl_pkg::REG_LOW_LIMIT, {24'h0, e});
        rd(atl_pkg::REG_STATUS, {24'h0, e});
    endtask
    task automatic temp(input logic l, input logic m, input logic [7:0] e);
        @(posedge clk_sys);
        tempAboveLow <= l;
        tempAboveMid <= m;
        // one edge: the level answers before any staircase step can land
        @(posedge clk_sys);
        #1 chk("level", {24'h0, e}, {24'h0, currentThrottleLevel});
    endtask
    task automatic win(input logic hot);
        @(posedge clk_sys);
        windowEnd <= 1'b1;
        windowOverLimit <= hot;
        @(posedge clk_sys);
        windowEnd <= 1'b0;
        windowOverLimit <= 1'b0;
    endtask
    task automatic glb(input logic e, input logic [7:0] lv);
        #1 chk("global", {31'h0, e}, {31'h0, globalThrottleStatus});
        chk("level", {24'h0, lv}, {24'h0, currentThrottleLevel});
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(atl_pkg::REG_LOW_LIMIT, 32'h0);
        rd(atl_pkg::REG_STATUS, 32'h0);
        rd(8'h70, 32'h0);
        lowChk(8'hFF, 8'hA8);
        lowChk(8'hA9, 8'hA8);
        lowChk(8'hA8, 8'hA8);
        lowChk(8'h05, 8'h05);
        wr(atl_pkg::REG_STATUS, 32'h1FF);
        rd(atl_pkg::REG_STATUS, 32'h5);
        wr(atl_pkg::REG_CONFIG, 32'hFFFF_FFFF);
        rd(atl_pkg::REG_CONFIG, 32'h0007_A8A8);
        wr(atl_pkg::REG_CONFIG, 32'h0003_0820);
        rd(atl_pkg::REG_CONFIG, 32'h0003_0820);
        temp(1'b0, 1'b0, 8'h05);
        temp(1'b1, 1'b0, 8'h20);
        temp(1'b1, 1'b1, 8'h08);
        temp(1'b0, 1'b0, 8'h05);
        wr(atl_pkg::REG_CONFIG, 32'h0001_0820);
        temp(1'b1, 1'b1, 8'h20);
        repeat (520) @(posedge clk_sys);
        glb(1'b0, 8'h08);
        wr(atl_pkg::REG_CONFIG, 32'h0000_0820);
        temp(1'b1, 1'b1, 8'h05);
        win(1'b1);
        glb(1'b1, 8'h20);
        rd(atl_pkg::REG_STATUS, 32'h0000_0120);
        repeat (15) win(1'b0);
        glb(1'b1, 8'h20);
        win(1'b0);
        glb(1'b0, 8'h05);
        wr(atl_pkg::REG_CONFIG, 32'h0007_0820);
        win(1'b1);
        glb(1'b1, 8'h08);
        win(1'b0);
        temp(1'b0, 1'b0, 8'h20);
        win(1'b0);
        glb(1'b0, 8'h05);
        stop_test;
    end
    // the sequence needs about 630 cycles; 8000 means a hang
    initial begin
        #400000;
        errors++;
        stop_test;
    end
endmodule
